// *** rtl/eeps_defines.vh ***
// Notes on behaviour
// - Read needs read arm set beforehand.
// - Read go with arm starts read.
// - CPU stalled during cycle, released after.
// - Read go cleared; word in data pair.
// - Data pair holds until next operation.
// - Write/erase go must follow arm immediately.
// - Low-power entry aborts running operation.
// - Upper control bits select 2-16 ms.
// - No address auto-increment between reads.
// - Erase zeroes 16-word page, bit four.
// - Go without arm ignored; clear both.
// - Five address bits, fourteen data bits.
`ifndef EEPS_DEFINES_VH
`define EEPS_DEFINES_VH

// Word offsets on the register bus
`define EEPS_OFF_ADDR    3'h0
`define EEPS_OFF_LOW     3'h1
`define EEPS_OFF_HIGH    3'h2
`define EEPS_OFF_CTRL    3'h3
`define EEPS_OFF_STAT    3'h4

// Control register fields
`define EEPS_CTL_RD_GO   0
`define EEPS_CTL_RD_ARM  1
`define EEPS_CTL_WR_GO   2
`define EEPS_CTL_WR_ARM  3
`define EEPS_CTL_ER_GO   4
`define EEPS_CTL_ER_ARM  5
`define EEPS_CTL_TSEL_LO 6
`define EEPS_CTL_TSEL_HI 7

// Status register fields
`define EEPS_ST_BUSY     0
`define EEPS_ST_ABORT    1

// Reset values
`define EEPS_RST_ADDR    5'h00
`define EEPS_RST_LOW     8'h00
`define EEPS_RST_HIGH    6'h00
`define EEPS_RST_CTRL    8'h00

// Widths
`define EEPS_AW          5
`define EEPS_DW          14
`define EEPS_PAGE_WORDS  16

// Timing
`define EEPS_CLK_HZ      10000000
`define EEPS_LS_HZ       32000
`define EEPS_PROG_MIN_MS 2
`define EEPS_LS_DIV      (`EEPS_CLK_HZ / `EEPS_LS_HZ)
`define EEPS_PROG_TICKS  (`EEPS_PROG_MIN_MS * `EEPS_LS_HZ / 1000)
`define EEPS_READ_CYC    12'h003

`endif

// *** rtl/eeps_tick_div.v ***
`timescale 1ns/10ps
`default_nettype none
module eeps_tick_div #(
  parameter DIV = 312
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Control
  input  wire        run_i,
  // Tick out
  output reg         tick_o
);

  reg [15:0] cnt_reg;

  // Low-speed period divider, restarts when idle
  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b0;
    end else if (cnt_reg == DIV[15:0] - 16'h0001) begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick_o  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** rtl/eeps_store.v ***
`timescale 1ns/10ps
`default_nettype none
module eeps_store #(
  parameter AW   = 5,
  parameter DW   = 14,
  parameter PAGE = 16
) (
  // Clock
  input  wire          clk_i,
  // Word access
  input  wire [AW-1:0] addr_i,
  input  wire          we_i,
  input  wire [DW-1:0] wdata_i,
  output reg  [DW-1:0] rdata_o,
  // Page erase
  input  wire          erase_i
);

  localparam WORDS = 1 << AW;
  localparam PB    = $clog2(PAGE);

  reg [DW-1:0] mem [0:WORDS-1];
  integer      i;

  // Word write, page clear, registered read
  always @(posedge clk_i) begin
    rdata_o <= mem[addr_i];
    if (erase_i) begin
      for (i = 0; i < WORDS; i = i + 1) begin
        if (i[AW-1:PB] == addr_i[AW-1:PB])
          mem[i] <= {DW{1'b0}};
      end
    end else if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

endmodule
`default_nettype wire

// *** rtl/eeps_top.v ***
`timescale 1ns/10ps
`default_nettype none
`include "eeps_defines.vh"
module eeps_top #(
  parameter LS_TICK_DIV     = `EEPS_LS_DIV,
  parameter PROG_BASE_TICKS = `EEPS_PROG_TICKS
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [4:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Core side
  input  wire        low_power_req_i,
  output reg         cpu_stall_o,
  output reg         busy_o
);

  // Sequencer states
  localparam ST_IDLE = 2'b00;
  localparam ST_READ = 2'b01;
  localparam ST_PROG = 2'b10;

  // Operation kinds
  localparam OP_RD = 2'b00;
  localparam OP_WR = 2'b01;
  localparam OP_ER = 2'b10;

  // Software-visible registers
  reg [4:0]  ee_word_address_reg;
  reg [7:0]  ee_word_low_reg;
  reg [5:0]  ee_word_high_reg;
  reg [1:0]  program_time_sel_reg;
  reg        read_arm_reg;
  reg        read_go_reg;
  reg        write_arm_reg;
  reg        write_go_reg;
  reg        erase_arm_reg;
  reg        erase_go_reg;
  reg        abort_reg;

  // Sequencer state
  reg [1:0]  state_reg;
  reg [1:0]  op_reg;
  reg [11:0] cnt_reg;
  reg        wr_just_armed_reg;
  reg        er_just_armed_reg;

  // Store control
  reg        st_we_reg;
  reg        st_erase_reg;

  wire [13:0] st_rdata;
  wire        ls_tick;
  wire        req;
  wire        wr;
  wire        ctl_wr;
  wire        stat_wr;
  wire [7:0]  wb0;
  wire [7:0]  ctl_now;
  wire [7:0]  stat_now;
  wire        start_rd;
  wire        start_wr;
  wire        start_er;
  wire [11:0] prog_ticks;
  wire        lp_abort;

  // Tick source for program time
  eeps_tick_div #(
    .DIV (LS_TICK_DIV)
  ) u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (state_reg == ST_PROG),
    .tick_o (ls_tick)
  );

  // Word storage
  eeps_store #(
    .AW   (`EEPS_AW),
    .DW   (`EEPS_DW),
    .PAGE (`EEPS_PAGE_WORDS)
  ) u_store (
    .clk_i   (clk_i),
    .addr_i  (ee_word_address_reg),
    .we_i    (st_we_reg),
    .wdata_i ({ee_word_high_reg, ee_word_low_reg}),
    .rdata_o (st_rdata),
    .erase_i (st_erase_reg)
  );

  // Control register as read back
  function [7:0] ctl_pack;
    input [1:0] ts;
    input       ea, eg, wa, wg, ra, rg;
    begin
      ctl_pack = {ts, ea, eg, wa, wg, ra, rg};
    end
  endfunction

  // Register select from a byte address
  function off_hit;
    input [4:0] a;
    input [2:0] off;
    begin
      off_hit = (a[4:2] == off);
    end
  endfunction

  assign ctl_now = ctl_pack(program_time_sel_reg, erase_arm_reg, erase_go_reg,
                            write_arm_reg, write_go_reg, read_arm_reg, read_go_reg);

  // Status register as read back
  assign stat_now = {6'h00, abort_reg, busy_o};

  // Bus decode; access taken the cycle before ack rises
  assign req     = cyc_i & stb_i & ~ack_o;
  assign wr      = req & we_i & sel_i[0];
  assign wb0     = dat_i[7:0];
  assign ctl_wr  = wr & off_hit(adr_i, `EEPS_OFF_CTRL);
  assign stat_wr = wr & off_hit(adr_i, `EEPS_OFF_STAT);

  // Go accepted only with arm already set; write/erase back to back
  assign start_er = ctl_wr & (state_reg == ST_IDLE) & wb0[`EEPS_CTL_ER_GO]
                    & erase_arm_reg & er_just_armed_reg;
  assign start_wr = ctl_wr & (state_reg == ST_IDLE) & wb0[`EEPS_CTL_WR_GO]
                    & write_arm_reg & wr_just_armed_reg & ~start_er;
  assign start_rd = ctl_wr & (state_reg == ST_IDLE) & wb0[`EEPS_CTL_RD_GO]
                    & read_arm_reg & ~start_er & ~start_wr;

  // Program duration doubles per select step
  assign prog_ticks = PROG_BASE_TICKS[11:0] << program_time_sel_reg;

  // Low-power entry from the core, same clock
  assign lp_abort = low_power_req_i & (state_reg != ST_IDLE);

  // Wishbone answer: one wait, ack for one cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req;
      if (req && !we_i) begin
        case (adr_i[4:2])
          `EEPS_OFF_ADDR: dat_o <= {27'h0000000, ee_word_address_reg};
          `EEPS_OFF_LOW:  dat_o <= {24'h000000, ee_word_low_reg};
          `EEPS_OFF_HIGH: dat_o <= {26'h0000000, ee_word_high_reg};
          `EEPS_OFF_CTRL: dat_o <= {24'h000000, ctl_now};
          `EEPS_OFF_STAT: dat_o <= {24'h000000, stat_now};
          default:        dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Address and data registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      ee_word_address_reg <= `EEPS_RST_ADDR;
      ee_word_low_reg     <= `EEPS_RST_LOW;
      ee_word_high_reg    <= `EEPS_RST_HIGH;
    end else if (state_reg == ST_READ && cnt_reg == 12'h000 && !lp_abort) begin
      // Read result kept until the next operation
      ee_word_low_reg  <= st_rdata[7:0];
      ee_word_high_reg <= st_rdata[13:8];
    end else if (wr && state_reg == ST_IDLE) begin
      // Address moves only on a bus write
      case (adr_i[4:2])
        `EEPS_OFF_ADDR: ee_word_address_reg <= wb0[4:0];
        `EEPS_OFF_LOW:  ee_word_low_reg     <= wb0;
        `EEPS_OFF_HIGH: ee_word_high_reg    <= wb0[5:0];
        default:        ee_word_address_reg <= ee_word_address_reg;
      endcase
    end
  end

  // Back-to-back tracking of arm writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_just_armed_reg <= 1'b0;
      er_just_armed_reg <= 1'b0;
    end else if (wr) begin
      wr_just_armed_reg <= ctl_wr & wb0[`EEPS_CTL_WR_ARM] & ~write_arm_reg;
      er_just_armed_reg <= ctl_wr & wb0[`EEPS_CTL_ER_ARM] & ~erase_arm_reg;
    end
  end

  // Control bits and sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      program_time_sel_reg <= 2'b00;
      read_arm_reg  <= 1'b0;
      read_go_reg   <= 1'b0;
      write_arm_reg <= 1'b0;
      write_go_reg  <= 1'b0;
      erase_arm_reg <= 1'b0;
      erase_go_reg  <= 1'b0;
      abort_reg     <= 1'b0;
      state_reg     <= ST_IDLE;
      op_reg        <= OP_RD;
      cnt_reg       <= 12'h000;
      st_we_reg     <= 1'b0;
      st_erase_reg  <= 1'b0;
      cpu_stall_o   <= 1'b0;
      busy_o        <= 1'b0;
    end else begin
      st_we_reg    <= 1'b0;
      st_erase_reg <= 1'b0;
      // Abort flag: set wins over a write-one clear
      if (stat_wr && wb0[`EEPS_ST_ABORT] && !lp_abort)
        abort_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (ctl_wr) begin
            // Arm, select and go written together
            program_time_sel_reg <= wb0[`EEPS_CTL_TSEL_HI:`EEPS_CTL_TSEL_LO];
            read_arm_reg  <= wb0[`EEPS_CTL_RD_ARM];
            write_arm_reg <= wb0[`EEPS_CTL_WR_ARM];
            erase_arm_reg <= wb0[`EEPS_CTL_ER_ARM];
            read_go_reg   <= start_rd;
            write_go_reg  <= start_wr;
            erase_go_reg  <= start_er;
            if (start_rd) begin
              state_reg   <= ST_READ;
              op_reg      <= OP_RD;
              cnt_reg     <= `EEPS_READ_CYC - 12'h001;
              cpu_stall_o <= 1'b1;
              busy_o      <= 1'b1;
            end else if (start_wr || start_er) begin
              state_reg   <= ST_PROG;
              op_reg      <= start_er ? OP_ER : OP_WR;
              cnt_reg     <= prog_ticks - 12'h001;
              cpu_stall_o <= 1'b1;
              busy_o      <= 1'b1;
            end
          end
        end
        ST_READ: begin
          if (lp_abort) begin
            abort_reg   <= 1'b1;
            read_go_reg <= 1'b0;
            state_reg   <= ST_IDLE;
            cpu_stall_o <= 1'b0;
            busy_o      <= 1'b0;
          end else if (cnt_reg == 12'h000) begin
            read_go_reg <= 1'b0;
            state_reg   <= ST_IDLE;
            cpu_stall_o <= 1'b0;
            busy_o      <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 12'h001;
          end
        end
        ST_PROG: begin
          if (lp_abort) begin
            // Nothing committed; operation fails
            abort_reg   <= 1'b1;
            state_reg   <= ST_IDLE;
            cpu_stall_o <= 1'b0;
            busy_o      <= 1'b0;
            if (op_reg == OP_ER) begin
              erase_arm_reg <= 1'b0;
              erase_go_reg  <= 1'b0;
            end else begin
              write_arm_reg <= 1'b0;
              write_go_reg  <= 1'b0;
            end
          end else if (ls_tick) begin
            if (cnt_reg == 12'h000) begin
              state_reg   <= ST_IDLE;
              cpu_stall_o <= 1'b0;
              busy_o      <= 1'b0;
              if (op_reg == OP_ER) begin
                st_erase_reg  <= 1'b1;
                erase_arm_reg <= 1'b0;
                erase_go_reg  <= 1'b0;
              end else begin
                st_we_reg     <= 1'b1;
                write_arm_reg <= 1'b0;
                write_go_reg  <= 1'b0;
              end
            end else begin
              cnt_reg <= cnt_reg - 12'h001;
            end
          end
        end
        default: begin
          state_reg   <= ST_IDLE;
          cpu_stall_o <= 1'b0;
          busy_o      <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** testbench/eeps_top_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module eeps_top_monitor #(
  parameter LS_TICK_DIV     = 4,
  parameter PROG_BASE_TICKS = 2
) (
  // Clock, reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [4:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Core side
  input wire logic        low_power_req_i,
  input wire logic        cpu_stall_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] cnt_reg;
  logic [1:0] tsel_reg;
  logic       prog_reg;
  logic       stop_reg;
  int         ticks;
  // Stall length, its start command and any abort
  always_ff @(posedge clk_i) begin
    cnt_reg <= (rst_i || !cpu_stall_o) ? 8'h00 : cnt_reg + 8'h01;
    if (cpu_stall_o && cnt_reg == 8'h00) begin
      tsel_reg <= dat_i[7:6];
      prog_reg <= dat_i[4] | dat_i[2];
    end
    stop_reg <= cpu_stall_o && (low_power_req_i || (stop_reg && cnt_reg != 8'h00));
  end
  assign ticks = PROG_BASE_TICKS << tsel_reg;
  // Checks
  stall_busy_a: assert property (cpu_stall_o == busy_o)
    else $error("stall and busy differ");
  stall_start_a: assert property ($rose(cpu_stall_o) |-> ack_o && we_i && adr_i[4:2] == 3'h3)
    else $error("stall began without control write");
  read_len_a: assert property ($rose(cpu_stall_o) && !dat_i[4] && !dat_i[2] |-> cpu_stall_o [*3] ##1 !cpu_stall_o)
    else $error("read stall length wrong");
  prog_time_a: assert property ($fell(cpu_stall_o) && prog_reg && !stop_reg |->
    cnt_reg >= (ticks - 1) * LS_TICK_DIV && cnt_reg <= (ticks + 1) * LS_TICK_DIV + 2) else $error("program time wrong");
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("access not answered");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  abort_end_a: assert property (low_power_req_i && busy_o |=> !busy_o)
    else $error("low power did not end operation");
  upper_zero_a: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0 &&
    (adr_i[4:2] != 3'h2 || dat_o[7:6] == 2'h0) && (adr_i[4:2] != 3'h0 || dat_o[7:5] == 3'h0))
    else $error("unimplemented bits not zero");
  cover property ($rose(cpu_stall_o) && dat_i[0]);
  cover property ($fell(cpu_stall_o) && prog_reg && !stop_reg);
  cover property (low_power_req_i && busy_o);
endmodule
bind eeps_top eeps_top_monitor #(.LS_TICK_DIV(LS_TICK_DIV), .PROG_BASE_TICKS(PROG_BASE_TICKS)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .low_power_req_i(low_power_req_i),
  .cpu_stall_o(cpu_stall_o), .busy_o(busy_o));
`default_nettype wire

// *** testbench/eeps_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module eeps_cpu_model (
  // Clock
  input wire logic        clk_i,
  // Bus
  output logic            cyc_o,
  output logic            stb_o,
  output logic            we_o,
  output logic [4:0]      adr_o,
  output logic [3:0]      sel_o,
  output logic [31:0]     dat_o,
  input wire logic [31:0] dat_i,
  input wire logic        ack_i
);
  logic [7:0] q;
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // One classic cycle, held until ack is sampled
  task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o} <= {2'b11, w, a, 4'hF};
    dat_o <= {24'h000000, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i[7:0];
    {cyc_o, stb_o, we_o} <= 3'b000;
    dat_o <= ~dat_o;
  endtask
  // Poll a go bit until hardware clears it
  task automatic poll(input int b);
    do access(1'b0, 5'h0C, 8'h00); while (q[b] !== 1'b0);
  endtask
  // Timing first, then arm, then go in the very next write
  task automatic launch(input logic [7:0] c, input logic [7:0] arm, input logic [7:0] go);
    access(1'b1, 5'h0C, c);
    access(1'b1, 5'h0C, c | arm);
    access(1'b1, 5'h0C, c | arm | go);
  endtask
endmodule
`default_nettype wire

// *** testbench/emulated_eeprom_sequencer_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module emulated_eeprom_sequencer_tb_top;
  typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} eeps_row_t;
  logic        clk_i;
  logic        rst_i;
  logic        low_power_req_i;
  wire         cyc, stb, we, ack, stall, busy;
  wire  [4:0]  adr;
  wire  [3:0]  sel;
  wire  [31:0] wdat;
  wire  [31:0] rdat;
  int          n_errors;
  int          tests_run;
  int          cycles;
  eeps_row_t   rows[6];
  eeps_top #(.LS_TICK_DIV(4), .PROG_BASE_TICKS(2)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .low_power_req_i(low_power_req_i),
    .cpu_stall_o(stall), .busy_o(busy));
  eeps_cpu_model u_cpu (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
  // Compare and verdict
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Register access helpers
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_cpu.access(1'b1, a, d);
  endtask
  task automatic rdchk(input string n, input logic [4:0] a, input logic [7:0] e);
    u_cpu.access(1'b0, a, 8'h00);
    chk8(n, e, u_cpu.q);
  endtask
  task automatic put(input logic [4:0] a, input logic [7:0] lo, input logic [7:0] hi, input logic [1:0] s);
    wr(5'h00, {3'h0, a});
    wr(5'h04, lo);
    wr(5'h08, hi);
    u_cpu.launch({s, 6'h00}, 8'h08, 8'h04);
    u_cpu.poll(2);
    rdchk("ctrl after write", 5'h0C, {s, 6'h00});
  endtask
  task automatic get(input logic [4:0] a, input logic [7:0] lo, input logic [7:0] hi);
    wr(5'h00, {3'h0, a});
    wr(5'h0C, 8'h02);
    wr(5'h0C, 8'h03);
    u_cpu.poll(0);
    rdchk("word low", 5'h04, lo);
    rdchk("word high", 5'h08, hi);
  endtask
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Hang guard
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk_i);
      cycles++;
      if (cycles > 20000) begin
        n_errors++;
        summarize();
      end
    end
  end
  // Main sequence
  initial begin
    rows = '{'{5'h00, 8'hFF, 8'h1F}, '{5'h04, 8'hA5, 8'hA5}, '{5'h08, 8'hFF, 8'h3F},
             '{5'h0C, 8'hC0, 8'hC0}, '{5'h14, 8'h55, 8'h00}, '{5'h0C, 8'h00, 8'h00}};
    n_errors = 0;
    tests_run = 0;
    rst_i = 1'b1;
    low_power_req_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) rdchk("reset value", 5'(i * 4), 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdchk("table row", rows[i].a, rows[i].e);
    end
    // Writes at every duration, read back word by word
    for (int s = 0; s < 4; s++) put(5'(s + 3), 8'(8'h30 + s), 8'(8'h10 + s), 2'(s));
    put(5'h13, 8'h5A, 8'h2A, 2'h0);
    for (int s = 0; s < 4; s++) get(5'(s + 3), 8'(8'h30 + s), 8'(8'h10 + s));
    get(5'h13, 8'h5A, 8'h2A);
    // Held data; go without arm, arm with go, late go
    wr(5'h00, 8'h00);
    rdchk("held low", 5'h04, 8'h5A);
    wr(5'h0C, 8'h00);
    wr(5'h0C, 8'h01);
    chk8("busy go no arm", 8'h00, {7'h00, busy});
    wr(5'h0C, 8'h0C);
    chk8("busy same write", 8'h00, {7'h00, busy});
    wr(5'h0C, 8'h08);
    wr(5'h00, 8'h03);
    wr(5'h0C, 8'h0C);
    chk8("busy late go", 8'h00, {7'h00, busy});
    // Upper page erase at the longest duration
    wr(5'h0C, 8'h00);
    wr(5'h00, 8'h1F);
    u_cpu.launch(8'hC0, 8'h20, 8'h10);
    u_cpu.poll(4);
    rdchk("ctrl after erase", 5'h0C, 8'hC0);
    get(5'h13, 8'h00, 8'h00);
    get(5'h03, 8'h30, 8'h10);
    // Low-power entry aborts a write
    wr(5'h0C, 8'h00);
    wr(5'h04, 8'h77);
    u_cpu.launch(8'h40, 8'h08, 8'h04);
    chk8("stall during write", 8'h01, {7'h00, stall});
    rdchk("status busy", 5'h10, 8'h01);
    wr(5'h0C, 8'h03);
    chk8("busy go while busy", 8'h01, {7'h00, busy});
    low_power_req_i <= 1'b1;
    @(posedge clk_i);
    low_power_req_i <= 1'b0;
    @(posedge clk_i);
    chk8("busy after abort", 8'h00, {7'h00, busy});
    chk8("stall after abort", 8'h00, {7'h00, stall});
    rdchk("ctrl after abort", 5'h0C, 8'h40);
    rdchk("abort flag", 5'h10, 8'h02);
    wr(5'h10, 8'h02);
    rdchk("abort cleared", 5'h10, 8'h00);
    get(5'h03, 8'h30, 8'h10);
    // Reset in the middle of a write
    u_cpu.launch(8'h80, 8'h08, 8'h04);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk8("busy after reset", 8'h00, {7'h00, busy});
    rdchk("ctrl after reset", 5'h0C, 8'h00);
    rdchk("low after reset", 5'h04, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
